// >>> core/host_countdown_timer.sv
// Summary of operation
// R1 - Bit 31 run bit starts or stops timer
// R2 - Bit 30 selects repeated or single cycle
// R3 - Bit 29 starts timer at each link reset
// R4 - Preload is bits 23 to 0, LSB bit 0
// R5 - One count step lasts 80.14 ns; code rounds to 16 clocks of 5 ns, 80 ns
// R6 - Start copies preload, counter decrements per unit
// R7 - Zero sets expiry flag if enabled
// R8 - Auto-reload restarts timing at zero
// R9 - Single cycle stops after expiry
// R10 - Link-reset start disables run bit
// R11 - Unacknowledged flag never blocks reloading
// R12 - Bit 8 gates link events onto interrupt
// R13 - Unit tick gates every decrement
`timescale 1ns/100ps
`default_nettype none
`include "timer_defines.svh"

module host_countdown_timer
(
    input  wire logic                clock,
    input  wire logic                srst,
    input  wire timer_pkg::bus_req_t bus_req,
    output var  logic [31:0]         rdata,
    input  wire logic                link_reset_in,
    output var  logic                irq
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam logic [4:0]  UNIT_LAST  = 5'(`UNIT_CYCLES - 1);
    localparam logic [31:0] CTRL_RESET = `RST_TIMER_CTRL;
    localparam logic [31:0] GATE_RESET = `RST_IRQ_GATE;
    localparam logic [31:0] MASK_RESET = `RST_MASK;

    // ------------------------------------------------------------
    // Control, enable and status flag registers
    // ------------------------------------------------------------
    logic        timer_run_r;
    logic        auto_reload_mode_r;
    logic        start_on_link_reset_r;
    logic [23:0] preload_r;
    logic        link_event_irq_enable_r;
    logic        countdown_irq_enable_r;
    logic        expired_flag_r;

    // ------------------------------------------------------------
    // Timer state
    // ------------------------------------------------------------
    logic [23:0] count_r;
    logic [23:0] count_nxt;
    logic [4:0]  unit_cnt_r;
    logic        tick_r;
    logic [2:0]  reset_sync_r;
    logic        reset_level_r;

    // ------------------------------------------------------------
    // Strobes and decodes
    // ------------------------------------------------------------
    logic        reset_start;
    logic        sw_start;
    logic        sw_stop;
    logic        load;
    logic        expire;
    logic        ctrl_wr;
    logic        gate_wr;
    logic        mask_wr;
    logic        ack_clr;
    logic        reload;
    logic        one_shot_done;
    logic [23:0] start_value;

    // ------------------------------------------------------------
    // Read path and outputs
    // ------------------------------------------------------------
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [31:0] ctrl_view;
    logic [31:0] ack_view;
    logic [31:0] mask_view;
    logic [31:0] gate_view;
    logic        irq_r;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    assign ctrl_wr = bus_req.wr && (bus_req.addr == `OFS_TIMER_CTRL);
    assign gate_wr = bus_req.wr && (bus_req.addr == `OFS_IRQ_GATE);
    assign mask_wr = bus_req.wr && (bus_req.addr == `OFS_LINK_EVENT_MASK);
    assign ack_clr = bus_req.wr && (bus_req.addr == `OFS_LINK_EVENT_ACK) &&
                     bus_req.wdata[`BIT_TIMER_EXPIRED];

    // ------------------------------------------------------------
    // Link reset input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
            reset_sync_r <= 3'h0;
        else
            reset_sync_r <= {reset_sync_r[1:0], link_reset_in};
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            reset_level_r <= 1'b0;
        else if (reset_sync_r[1] == reset_sync_r[2])
            reset_level_r <= reset_sync_r[2];
    end

    assign reset_start = start_on_link_reset_r && !reset_level_r &&
                         reset_sync_r[1] && reset_sync_r[2];        // see R3

    // ------------------------------------------------------------
    // Start and stop decisions
    // ------------------------------------------------------------
    assign sw_start = ctrl_wr && !bus_req.wdata[`BIT_START_ON_RESET] &&
                      bus_req.wdata[`BIT_TIMER_RUN];                // see R1 see R10
    assign sw_stop  = ctrl_wr && !bus_req.wdata[`BIT_START_ON_RESET] &&
                      !bus_req.wdata[`BIT_TIMER_RUN];               // see R1 see R10
    assign load     = sw_start || reset_start;
    assign expire   = timer_run_r && tick_r && (count_r <= 24'h000001);
    assign reload   = expire && auto_reload_mode_r;
    assign one_shot_done = expire && !auto_reload_mode_r;

    // ------------------------------------------------------------
    // Start value
    // ------------------------------------------------------------
    // Write data bypasses the preload register written in the same cycle
    always_comb
    begin
        start_value = preload_r;
        if (sw_start)
            start_value = bus_req.wdata[`PRELOAD_MSB:0];            // see R6
    end

    // ------------------------------------------------------------
    // Time unit tick
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst || load)
        begin
            unit_cnt_r <= 5'h00;
            tick_r     <= 1'b0;
        end
        else if (unit_cnt_r == UNIT_LAST)
        begin
            unit_cnt_r <= 5'h00;
            tick_r     <= 1'b1;                                     // see R5 see R13
        end
        else
        begin
            unit_cnt_r <= unit_cnt_r + 5'h01;
            tick_r     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            auto_reload_mode_r    <= CTRL_RESET[`BIT_AUTO_RELOAD];
            start_on_link_reset_r <= CTRL_RESET[`BIT_START_ON_RESET];
            preload_r             <= CTRL_RESET[`PRELOAD_MSB:0];
        end
        else if (ctrl_wr)
        begin
            auto_reload_mode_r    <= bus_req.wdata[`BIT_AUTO_RELOAD];    // see R2
            start_on_link_reset_r <= bus_req.wdata[`BIT_START_ON_RESET]; // see R3
            preload_r             <= bus_req.wdata[`PRELOAD_MSB:0];      // see R4
        end
    end

    // ------------------------------------------------------------
    // Run state
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
            timer_run_r <= 1'b0;
        else if (load)
            timer_run_r <= 1'b1;                                    // see R1 see R3
        else if (sw_stop)
            timer_run_r <= 1'b0;                                    // see R1
        else if (one_shot_done)
            timer_run_r <= 1'b0;                                    // see R9
    end

    // ------------------------------------------------------------
    // Hidden counter
    // ------------------------------------------------------------
    always_comb
    begin
        count_nxt = count_r;
        if (load)
            count_nxt = start_value;                                // see R6
        else if (reload)
            count_nxt = preload_r;                                  // see R8 see R11
        else if (expire)
            count_nxt = 24'h000000;                                 // see R9
        else if (timer_run_r && tick_r)
            count_nxt = count_r - 24'h000001;                       // see R6 see R13
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            count_r <= 24'h000000;
        else
            count_r <= count_nxt;
    end

    // ------------------------------------------------------------
    // Interrupt registers
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
            link_event_irq_enable_r <= GATE_RESET[`BIT_LINK_EVENT_EN];
        else if (gate_wr)
            link_event_irq_enable_r <= bus_req.wdata[`BIT_LINK_EVENT_EN]; // see R12
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            countdown_irq_enable_r <= MASK_RESET[`BIT_TIMER_EXPIRED];
        else if (mask_wr)
            countdown_irq_enable_r <= bus_req.wdata[`BIT_TIMER_EXPIRED];  // see R7
    end

    // ------------------------------------------------------------
    // Expiry flag
    // ------------------------------------------------------------

    always_ff @(posedge clock)
    begin
        if (srst)
            expired_flag_r <= 1'b0;
        else if (expire && countdown_irq_enable_r)
            expired_flag_r <= 1'b1;                                 // see R7 see R11
        else if (ack_clr)
            expired_flag_r <= 1'b0;
    end

    // ------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
            irq_r <= 1'b0;
        else
            irq_r <= link_event_irq_enable_r && expired_flag_r &&
                     countdown_irq_enable_r;                        // see R12
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    assign ctrl_view = {timer_run_r, auto_reload_mode_r, start_on_link_reset_r,
                        5'h00, preload_r};                          // see R4
    assign ack_view  = {31'h0000_0000, expired_flag_r};
    assign mask_view = {31'h0000_0000, countdown_irq_enable_r};
    assign gate_view = {23'h000000, link_event_irq_enable_r, 8'h00};

    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        if (bus_req.rd)
        begin
            case (bus_req.addr)
                `OFS_TIMER_CTRL:
                    rdata_nxt = ctrl_view;
                `OFS_LINK_EVENT_ACK:
                    rdata_nxt = ack_view;
                `OFS_LINK_EVENT_MASK:
                    rdata_nxt = mask_view;
                `OFS_IRQ_GATE:
                    rdata_nxt = gate_view;
                default:
                    rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            rdata_r <= 32'h0000_0000;
        else
            rdata_r <= rdata_nxt;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata = rdata_r;
    assign irq   = irq_r;

endmodule

`default_nettype wire

// >>> core/timer_defines.svh
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_IRQ_GATE        8'h04
`define OFS_LINK_EVENT_ACK  8'h08
`define OFS_LINK_EVENT_MASK 8'h0C
`define OFS_TIMER_CTRL      8'h1C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_TIMER_RUN       31
`define BIT_AUTO_RELOAD     30
`define BIT_START_ON_RESET  29
`define PRELOAD_MSB         23
`define BIT_LINK_EVENT_EN   8
`define BIT_TIMER_EXPIRED   0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_TIMER_CTRL      32'h0000_0000
`define RST_IRQ_GATE        32'h0000_0000
`define RST_MASK            32'h0000_0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define UNIT_PS             80140
`define CLK_PS              5000
`define UNIT_CYCLES         ((`UNIT_PS + (`CLK_PS / 2)) / `CLK_PS)

`endif

// >>> core/timer_pkg.sv
package timer_pkg;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

endpackage

// >>> dv/host_countdown_timer_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module host_countdown_timer_asserts
(
    input wire logic                clock,
    input wire logic                srst,
    input wire timer_pkg::bus_req_t bus_req,
    input wire logic [31:0]         rdata,
    input wire logic                link_reset_in,
    input wire logic                irq
);
    // ----
    // Gate and mask shadow
    // ----
    logic [1:0] en_r;
    always_ff @(posedge clock)
    begin
        if (srst)
            en_r <= 2'h0;
        else if (bus_req.wr && bus_req.addr == 8'h04)
            en_r[0] <= bus_req.wdata[8];
        else if (bus_req.wr && bus_req.addr == 8'h0C)
            en_r[1] <= bus_req.wdata[0];
    end
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    sequence s_rd; bus_req.rd && bus_req.addr == 8'h1C; endsequence
    sequence s_go; bus_req.wr && bus_req.addr == 8'h1C && !bus_req.wdata[29]; endsequence
    property p_idle; !bus_req.rd |=> rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("rdata not zero");
    property p_unmap; bus_req.rd && bus_req.addr == 8'h10 |=> rdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_run; s_go ##0 bus_req.wdata[31] ##1 s_rd |=> rdata[31]; endproperty
    a_run: assert property (p_run) else $error("run not set");
    property p_stop; s_go ##0 !bus_req.wdata[31] ##1 s_rd |=> !rdata[31]; endproperty
    a_stop: assert property (p_stop) else $error("run not clear");
    property p_field; bus_req.wr && bus_req.addr == 8'h1C ##1 s_rd |=>
        rdata[30:29] == $past(bus_req.wdata[30:29], 2) &&
        rdata[23:0] == $past(bus_req.wdata[23:0], 2); endproperty
    a_field: assert property (p_field) else $error("ctrl readback");
    property p_gate; en_r != 2'h3 |=> !irq; endproperty
    a_gate: assert property (p_gate) else $error("irq not gated");
    property p_rise; $rose(irq) |-> $past(en_r) == 2'h3; endproperty
    a_rise: assert property (p_rise) else $error("irq rise");
    property p_exp; s_go ##0 (bus_req.wdata[31] && bus_req.wdata[23:0] == 24'h1
        && en_r == 2'h3 && !irq) |-> ##16 !irq ##3 irq; endproperty
    a_exp: assert property (p_exp) else $error("expiry time");
endmodule
bind host_countdown_timer host_countdown_timer_asserts i_chk (.clock(clock), .srst(srst),
    .bus_req(bus_req), .rdata(rdata), .link_reset_in(link_reset_in), .irq(irq));
`default_nettype wire

// >>> dv/tb_host_countdown_timer.sv
`timescale 1ns/100ps
`default_nettype none
module tb_host_countdown_timer;
    logic                clock;
    logic                srst;
    timer_pkg::bus_req_t bus_req;
    logic [31:0]         rdata;
    logic                link_reset_in;
    logic                irq;
    logic [31:0]         exp_q[$];
    logic [15:0]         seed;
    logic                rd_d;
    int                  errors;
    int                  num_checks;
    host_countdown_timer i_dut
    (
        .clock         (clock),
        .srst          (srst),
        .bus_req       (bus_req),
        .rdata         (rdata),
        .link_reset_in (link_reset_in),
        .irq           (irq)
    );
    // ----
    // Tasks
    // ----
    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(logic [31:0] seen, logic [31:0] e);
        num_checks++;
        if (seen !== e)
        begin
            errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, e);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        bus_req <= {a, d, 2'h2};
        @(posedge clock);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        bus_req <= {a, 32'h0, 2'h1};
        exp_q.push_back(e);
        @(posedge clock);
    endtask
    task automatic idle(int n);
        bus_req <= '0;
        repeat (n) @(posedge clock);
    endtask
    task automatic irq_is(int n, logic e);
        idle(n);
        @(negedge clock);
        check({31'h0, irq}, {31'h0, e});
        @(posedge clock);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clock)
    begin
        if (rd_d)
            check(rdata, exp_q.pop_front());
        rd_d <= bus_req.rd;
    end
    initial
    begin
        clock = 1'h0;
        forever #2.5 clock = ~clock;
    end
    initial
    begin
        repeat (5000) @(posedge clock);
        errors++;
        report_and_stop;
    end
    initial
    begin
        srst = 1'h1;
        bus_req = '0;
        link_reset_in = 1'h0;
        seed = 16'h0040;
        repeat (8) @(posedge clock);
        srst <= 1'h0;
        @(posedge clock);
        rd(8'h1C, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h0C, 32'h0);
        wr(8'h10, 32'hFFFFFFFF);
        rd(8'h10, 32'h0);
        repeat (4)
        begin
            seed = lfsr(seed);
            wr(8'h1C, {seed, lfsr(seed)} & 32'h40FFFFFF);
            rd(8'h1C, {seed, lfsr(seed)} & 32'h40FFFFFF);
        end
        wr(8'h1C, 32'hA0000003);
        rd(8'h1C, 32'h20000003);
        wr(8'h0C, 32'h1);
        wr(8'h04, 32'h100);
        rd(8'h04, 32'h100);
        $display("register readback done");
        wr(8'h1C, 32'h80000002);
        rd(8'h1C, 32'h80000002);
        irq_is(32, 1'h0);
        irq_is(1, 1'h1);
        rd(8'h1C, 32'h2);
        rd(8'h08, 32'h1);
        wr(8'h08, 32'h1);
        rd(8'h08, 32'h0);
        irq_is(40, 1'h0);
        $display("one-shot done");
        wr(8'h1C, 32'hC0000001);
        idle(100);
        rd(8'h1C, 32'hC0000001);
        wr(8'h08, 32'h1);
        irq_is(20, 1'h1);
        wr(8'h1C, 32'h40000001);
        rd(8'h1C, 32'h40000001);
        wr(8'h08, 32'h1);
        idle(40);
        rd(8'h08, 32'h0);
        $display("auto-reload done");
        wr(8'h0C, 32'h0);
        wr(8'h1C, 32'h80000001);
        idle(40);
        rd(8'h08, 32'h0);
        wr(8'h0C, 32'h1);
        wr(8'h04, 32'h0);
        wr(8'h1C, 32'h80000001);
        irq_is(40, 1'h0);
        rd(8'h08, 32'h1);
        wr(8'h04, 32'h100);
        irq_is(2, 1'h1);
        wr(8'h08, 32'h1);
        $display("gating done");
        wr(8'h1C, 32'hA0000001);
        irq_is(40, 1'h0);
        link_reset_in <= 1'h1;
        idle(4);
        link_reset_in <= 1'h0;
        irq_is(30, 1'h1);
        $display("link reset start done");
        report_and_stop;
    end
endmodule
`default_nettype wire
